// ==== serial_listener.sv ====
// Far-side receiver of a status frame: master bus or dispenser link
`timescale 1ns/10ps
module serial_listener
#(
    parameter int unsigned BAUD_C = 4,
    parameter bit          PARITY = 1'h0
)
(
    // Clock and line
    input wire logic sys_clk,
    input wire logic line,
    // Decoded frame
    output logic [7:0] rx_byte,
    output logic       frame_ok,
    output int         frames
);
    logic [7:0] b;
    logic       p;
    initial
    begin
        rx_byte = 8'h00;
        frame_ok = 1'h1;
        frames = 0;
        forever
        begin
            @(negedge line);
            // Sample mid-bit so clock skew of the sender does not matter
            repeat (BAUD_C / 2) @(posedge sys_clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BAUD_C) @(posedge sys_clk);
                b[i] = line;
            end
            p = ^b;
            if (PARITY)
            begin
                repeat (BAUD_C) @(posedge sys_clk);
                p = (line === ^b);
            end
            else
                p = 1'h1;
            repeat (BAUD_C) @(posedge sys_clk);
            frame_ok = p & (line === 1'h1);
            rx_byte = b;
            frames++;
        end
    end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the vapour monitor status block
`timescale 1ns/10ps
module testbench;
    import vapour_pkg::*;
    localparam int unsigned BAUD = 4;
    localparam int unsigned SLOW = 40, FAST = 20, VFAST = 8;
    logic         sys_clk, rst_n, pass_a, pass_b, day_tick, mode_per_fill, days_long, supply_low, supply_high;
    flow_seen_t   flow;
    lamp_colour_t lamp;
    logic         power_lamp, shutdown_a, shutdown_b, stray_alarm, device_error, bus_txd, disp_txd;
    logic [7:0]   bus_byte, disp_byte;
    logic         bus_ok, disp_ok;
    int           bus_frames, disp_frames;
    int           error_cnt = 0;
    int           cmp_count = 0;
    int           on_len;
    // Row: side_b, pass, shutdown_a, shutdown_b, frame byte with pending bits masked
    logic [11:0]  rows [4] = '{12'h205, 12'hB2D, 12'h528, 12'hC00};
    vapour_monitor_status_indicator #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .VFAST_CYC(VFAST), .PAUSE_C(100), .BAUD_C(BAUD))
    i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .flow_pin(flow), .pass_a(pass_a), .pass_b(pass_b), .day_tick(day_tick),
        .mode_per_fill(mode_per_fill), .days_long(days_long), .supply_low(supply_low), .supply_high(supply_high),
        .condition_lamp(lamp), .power_lamp(power_lamp), .shutdown_a(shutdown_a), .shutdown_b(shutdown_b),
        .stray_alarm(stray_alarm), .device_error(device_error), .bus_txd(bus_txd), .disp_txd(disp_txd));
    serial_listener #(.BAUD_C(BAUD)) i_bus (.sys_clk(sys_clk), .line(bus_txd), .rx_byte(bus_byte),
        .frame_ok(bus_ok), .frames(bus_frames));
    serial_listener #(.BAUD_C(BAUD), .PARITY(1'h1)) i_disp (.sys_clk(sys_clk), .line(disp_txd), .rx_byte(disp_byte),
        .frame_ok(disp_ok), .frames(disp_frames));
    initial
    begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Each fill is spaced past a full 11-bit frame so no report is dropped
    task automatic fill(input logic side_b, input logic fuel, input logic ok);
        @(posedge sys_clk);
        flow <= flow_seen_t'{!side_b, side_b, fuel & !side_b, fuel & side_b};
        pass_a <= ok;
        pass_b <= ok;
        repeat (10) @(posedge sys_clk);
        flow <= '0;
        repeat (70) @(posedge sys_clk);
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            day_tick <= 1'h1;
            repeat (6) @(posedge sys_clk);
            day_tick <= 1'h0;
            repeat (6) @(posedge sys_clk);
        end
    endtask
    task automatic wait_lamp(input lamp_colour_t col);
        int n;
        n = 0;
        while (lamp !== col && n < 800)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk("condition_lamp", col, lamp);
    endtask
    // Length of the next whole lit phase; the current one may have begun at the old rate
    task automatic lamp_on_len(output int len);
        int n;
        n = 0;
        len = 0;
        while (lamp !== LAMP_OFF && n < 800)
        begin
            @(posedge sys_clk);
            n++;
        end
        while (lamp === LAMP_OFF && n < 800)
        begin
            @(posedge sys_clk);
            n++;
        end
        while (lamp !== LAMP_OFF && n < 800)
        begin
            @(posedge sys_clk);
            n++;
            len++;
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
    initial
    begin
        {rst_n, pass_a, pass_b, day_tick, days_long, supply_low, supply_high} = '0;
        mode_per_fill = 1'h1;
        flow = '0;
        repeat (10) @(posedge sys_clk);
        chk("reset shutdown", 8'h00, {shutdown_a, shutdown_b, stray_alarm, power_lamp});
        chk("reset lamp", LAMP_OFF, lamp);
        chk("reset txd", 8'h03, {bus_txd, disp_txd});
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (10) @(posedge sys_clk);
        chk("power_lamp", 8'h01, power_lamp);
        for (int i = 0; i < 4; i++)
        begin
            fill(rows[i][11], 1'h1, rows[i][10]);
            chk("shutdown_a", rows[i][9], shutdown_a);
            chk("shutdown_b", rows[i][8], shutdown_b);
            chk("bus frame", rows[i][7:0], bus_byte & 8'hED);
            chk("disp frame", rows[i][7:0], disp_byte & 8'hED);
            chk("frame ok", 8'h01, bus_ok & disp_ok);
            chk("frames", 8'(i + 1), bus_frames[7:0]);
        end
        mode_per_fill <= 1'h0;
        fill(1'h0, 1'h1, 1'h0);
        wait_lamp(LAMP_ORANGE);
        tick(2);
        chk("shutdown_a", 8'h00, shutdown_a);
        tick(1);
        chk("shutdown_a", 8'h01, shutdown_a);
        wait_lamp(LAMP_RED);
        days_long <= 1'h1;
        fill(1'h1, 1'h1, 1'h0);
        wait_lamp(LAMP_ORANGE);
        tick(6);
        chk("shutdown_b", 8'h00, shutdown_b);
        tick(1);
        chk("shutdown_b", 8'h01, shutdown_b);
        fill(1'h0, 1'h1, 1'h1);
        fill(1'h1, 1'h1, 1'h1);
        chk("shutdown pair", 8'h00, {shutdown_a, shutdown_b});
        repeat (9) fill(1'h0, 1'h0, 1'h1);
        chk("stray_alarm", 8'h00, stray_alarm);
        fill(1'h0, 1'h0, 1'h1);
        chk("stray_alarm", 8'h01, stray_alarm);
        flow <= flow_seen_t'{1'h1, 1'h0, 1'h1, 1'h0};
        repeat (4) @(posedge sys_clk);
        lamp_on_len(on_len);
        chk("fast half", 8'(FAST), 8'(on_len));
        flow <= flow_seen_t'{1'h1, 1'h0, 1'h0, 1'h0};
        repeat (4) @(posedge sys_clk);
        lamp_on_len(on_len);
        chk("very fast half", 8'(VFAST), 8'(on_len));
        flow <= '0;
        repeat (4) @(posedge sys_clk);
        lamp_on_len(on_len);
        chk("slow half", 8'(SLOW), 8'(on_len));
        supply_high <= 1'h1;
        repeat (120) @(posedge sys_clk);
        chk("device_error", 8'h01, device_error);
        supply_high <= 1'h0;
        supply_low <= 1'h1;
        repeat (200) @(posedge sys_clk);
        chk("device_error", 8'h00, device_error);
        supply_low <= 1'h0;
        repeat (20) @(posedge sys_clk);
        chk("power_lamp", 8'h01, power_lamp);
        stop_test();
    end
endmodule
bind vapour_monitor_status_indicator vapour_properties #(.BAUD_C(BAUD_C)) i_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .pass_a(pass_a), .pass_b(pass_b), .supply_low(supply_low),
    .supply_high(supply_high), .condition_lamp(condition_lamp), .power_lamp(power_lamp), .shutdown_a(shutdown_a),
    .shutdown_b(shutdown_b), .stray_alarm(stray_alarm), .device_error(device_error), .bus_txd(bus_txd));

// ==== vapour_monitor_status_indicator.sv ====
// Status, countdown, lamp and serial report logic of the vapour monitor
`timescale 1ns/10ps

module vapour_monitor_status_indicator
    import vapour_pkg::*;
#(
    parameter int unsigned SLOW_CYC  = SLOW_HALF_CYC,
    parameter int unsigned FAST_CYC  = FAST_HALF_CYC,
    parameter int unsigned VFAST_CYC = VFAST_HALF_CYC,
    parameter int unsigned PAUSE_C   = PAUSE_CYC,
    parameter int unsigned BAUD_C    = BAUD_CYCLES
)
(
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    // Side flow activity from transmitters and dispenser (pins)
    input  wire vapour_pkg::flow_seen_t       flow_pin,
    // Per-fill evaluation result: vapour matches fuel reference
    input  wire logic                         pass_a,
    input  wire logic                         pass_b,
    // Configuration and supervision pins
    input  wire logic                         day_tick,
    input  wire logic                         mode_per_fill,
    input  wire logic                         days_long,
    input  wire logic                         supply_low,
    input  wire logic                         supply_high,
    // Lamps
    output      vapour_pkg::lamp_colour_t     condition_lamp,
    output      logic                         power_lamp,
    // Shutdown and alarms
    output      logic                         shutdown_a,
    output      logic                         shutdown_b,
    output      logic                         stray_alarm,
    output      logic                         device_error,
    // Serial lines
    output      logic                         bus_txd,
    output      logic                         disp_txd
);
    import vapour_pkg::*;

    if (SLOW_CYC <= FAST_CYC || FAST_CYC <= VFAST_CYC || VFAST_CYC < 2 || BAUD_C < 2 || BAUD_C > 65536)
    begin : g_bad_params
        $error("blink rates must be strictly ordered and baud divider within 2 to 65536");
    end

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [8:0] sync1_q, sync2_q, sync3_q;
    wire  [8:0] raw_in = {flow_pin, day_tick, supply_low, supply_high, mode_per_fill, days_long};
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
            sync3_q <= 9'h000;
        end
        else
        begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end

    wire flow_seen_t fl   = sync2_q[8:5];
    wire flow_seen_t fl_p = sync3_q[8:5];
    wire tick_rise = sync2_q[4] & ~sync3_q[4];
    wire s_low     = sync2_q[3];
    wire s_high    = sync2_q[2];
    wire per_fill  = sync2_q[1];
    wire [3:0] limit_days = sync2_q[0] ? 4'(DAYS_LONG) : 4'(DAYS_SHORT);

    // ----------------------------------------------------------------
    // Fill end detection per side
    // ----------------------------------------------------------------
    wire end_a   = fl_p.fuel_a & ~fl.fuel_a;
    wire end_b   = fl_p.fuel_b & ~fl.fuel_b;
    wire stray_a = fl_p.vapour_a & ~fl.vapour_a & ~fl_p.fuel_a;
    wire stray_b = fl_p.vapour_b & ~fl.vapour_b & ~fl_p.fuel_b;
    wire fuel_on = fl.fuel_a | fl.fuel_b;
    wire stray_on = (fl.vapour_a & ~fl.fuel_a) | (fl.vapour_b & ~fl.fuel_b);

    // ----------------------------------------------------------------
    // Per-side countdown
    // ----------------------------------------------------------------
    side_state_t st_q [2];
    logic [3:0]  days_q [2];
    wire ends [2] = '{end_a, end_b};
    wire pass [2] = '{pass_a, pass_b};

    for (genvar s = 0; s < 2; s++)
    begin : g_side
        wire fail_now = ends[s] & ~pass[s];
        always_ff @(posedge sys_clk or negedge rst_n)
            if (!rst_n)
            begin
                st_q[s]   <= '0;
                days_q[s] <= 4'h0;
            end
            else if (ends[s] && pass[s])
            begin
                st_q[s]   <= '0;
                days_q[s] <= 4'h0;
            end
            else if (per_fill)
            begin
                st_q[s]   <= fail_now ? 3'b101 : (ends[s] ? 3'b000 : st_q[s]);
                days_q[s] <= 4'h0;
            end
            else if (fail_now && !st_q[s].fault)
            begin
                st_q[s]   <= 3'b110;
                days_q[s] <= 4'h0;
            end
            else if (st_q[s].pending && tick_rise)
            begin
                days_q[s] <= days_q[s] + 4'h1;
                if (days_q[s] + 4'h1 >= limit_days)
                    st_q[s] <= 3'b101;
            end
    end

    // ----------------------------------------------------------------
    // Stray vapour alarm counter
    // ----------------------------------------------------------------
    logic [3:0] stray_cnt_q;
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            stray_cnt_q <= 4'h0;
        else if ((stray_a || stray_b) && stray_cnt_q != 4'(STRAY_ALARM))
            stray_cnt_q <= stray_cnt_q + 4'h1;

    // ----------------------------------------------------------------
    // Blink generator
    // ----------------------------------------------------------------
    // One divider for all condition lamp rates keeps the condition lamp phases coherent
    logic [31:0] div_q;
    logic        ph_q;
    logic [3:0]  blink_q;
    logic        pause_q;
    wire  [31:0] half = stray_on ? VFAST_CYC : (fuel_on ? FAST_CYC : SLOW_CYC);
    wire  [3:0]  burst = per_fill ? 4'h0 : limit_days;
    wire         div_done = div_q >= (pause_q ? PAUSE_C - 1 : half - 1);
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
            div_q   <= '0;
            ph_q    <= 1'b0;
            blink_q <= 4'h0;
            pause_q <= 1'b0;
        end
        else if (!div_done)
            div_q <= div_q + 32'h1;
        else
        begin
            div_q <= '0;
            if (pause_q)
                pause_q <= 1'b0;
            else if (ph_q && burst != 4'h0 && blink_q + 4'h1 >= burst)
            begin
                ph_q    <= 1'b0;
                blink_q <= 4'h0;
                pause_q <= 1'b1;
            end
            else
            begin
                ph_q <= ~ph_q;
                if (ph_q)
                    blink_q <= blink_q + 4'h1;
            end
        end

    function automatic lamp_colour_t side_colour(side_state_t s);
        side_colour = s.expired ? LAMP_RED : (s.pending ? LAMP_ORANGE : LAMP_GREEN);
    endfunction

    wire lamp_colour_t colour_now =
        !ph_q ? LAMP_OFF :
        (blink_q == 4'h0) ? side_colour(st_q[0]) :
        (blink_q == 4'h1) ? side_colour(st_q[1]) :
        LAMP_GREEN;

    // ----------------------------------------------------------------
    // Power lamp
    // ----------------------------------------------------------------
    logic [31:0] pdiv_q;
    logic        pph_q;
    wire  [31:0] phalf = s_high ? FAST_CYC : SLOW_CYC;
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
            pdiv_q <= '0;
            pph_q  <= 1'b0;
        end
        else if (pdiv_q >= phalf - 1)
        begin
            pdiv_q <= '0;
            pph_q  <= ~pph_q;
        end
        else
            pdiv_q <= pdiv_q + 32'h1;
    wire power_now = s_high ? pph_q :
                     s_low  ? pph_q : 1'b1;

    // ----------------------------------------------------------------
    // Serial status reporters
    // ----------------------------------------------------------------
    // A status byte leaves after each evaluation; a new one during a bus frame is dropped
    wire [7:0] status_byte = {stray_alarm, s_high, st_q[1], st_q[0]};
    wire       send = end_a | end_b;
    logic      send_q;                                       // Delay so the frame carries the updated side state
    logic [10:0] sh_bus_q, sh_disp_q;
    logic [3:0]  nb_bus_q, nb_disp_q;
    logic [15:0] bdiv_q;
    wire         bit_end = bdiv_q >= 16'(BAUD_C - 1);
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
            sh_bus_q  <= '1;
            sh_disp_q <= '1;
            nb_bus_q  <= 4'h0;
            nb_disp_q <= 4'h0;
            bdiv_q    <= 16'h0000;
            send_q    <= 1'b0;
        end
        else
        begin
            bdiv_q <= bit_end ? 16'h0000 : bdiv_q + 16'h0001;
            send_q <= send;
            if (send_q && nb_bus_q == 4'h0)
            begin
                sh_bus_q  <= {2'b11, status_byte, 1'b0};
                nb_bus_q  <= 4'(FRAME_BUS);
                sh_disp_q <= {1'b1, ^status_byte, status_byte, 1'b0};
                nb_disp_q <= 4'(FRAME_DISP);
                bdiv_q    <= 16'h0000;
            end
            else if (bit_end)
            begin
                if (nb_bus_q != 4'h0)
                begin
                    sh_bus_q <= {1'b1, sh_bus_q[10:1]};
                    nb_bus_q <= nb_bus_q - 4'h1;
                end
                if (nb_disp_q != 4'h0)
                begin
                    sh_disp_q <= {1'b1, sh_disp_q[10:1]};
                    nb_disp_q <= nb_disp_q - 4'h1;
                end
            end
        end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
        begin
            condition_lamp <= LAMP_OFF;
            power_lamp     <= 1'b0;
            shutdown_a     <= 1'b0;
            shutdown_b     <= 1'b0;
            stray_alarm    <= 1'b0;
            device_error   <= 1'b0;
            bus_txd        <= 1'b1;
            disp_txd       <= 1'b1;
        end
        else
        begin
            condition_lamp <= colour_now;
            power_lamp     <= power_now;
            shutdown_a     <= st_q[0].expired;
            shutdown_b     <= st_q[1].expired;
            stray_alarm    <= stray_cnt_q == 4'(STRAY_ALARM);
            device_error   <= s_high;
            bus_txd        <= sh_bus_q[0];
            disp_txd       <= sh_disp_q[0];
        end
endmodule

// ==== vapour_pkg.sv ====
// Shared constants and carrier types for the vapour monitor status block
package vapour_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned BAUD_RATE      = 9600;
    localparam int unsigned BAUD_CYCLES    = CLK_HZ / BAUD_RATE;
    localparam int unsigned SLOW_HALF_MS   = 500;
    localparam int unsigned FAST_HALF_MS   = 150;
    localparam int unsigned VFAST_HALF_MS  = 50;
    localparam int unsigned PAUSE_MS       = 2000;
    localparam int unsigned SLOW_HALF_CYC  = SLOW_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned FAST_HALF_CYC  = FAST_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned VFAST_HALF_CYC = VFAST_HALF_MS * (CLK_HZ / 1000);
    localparam int unsigned PAUSE_CYC      = PAUSE_MS * (CLK_HZ / 1000);
    localparam int unsigned DAYS_SHORT     = 3;
    localparam int unsigned DAYS_LONG      = 7;
    localparam int unsigned STRAY_ALARM    = 10;

    // ----------------------------------------------------------------
    // Link framing
    // ----------------------------------------------------------------
    localparam int unsigned DATA_BITS      = 8;
    localparam int unsigned FRAME_BUS      = 10;
    localparam int unsigned FRAME_DISP     = 11;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {LAMP_OFF, LAMP_GREEN, LAMP_ORANGE, LAMP_RED} lamp_colour_t;

    typedef struct packed {
        logic fault;
        logic pending;
        logic expired;
    } side_state_t;

    typedef struct packed {
        logic vapour_a;
        logic vapour_b;
        logic fuel_a;
        logic fuel_b;
    } flow_seen_t;

endpackage

// ==== vapour_properties.sv ====
// Concurrent checks on the ports of the vapour monitor status block
`timescale 1ns/10ps
module vapour_properties
    import vapour_pkg::*;
#(
    parameter int unsigned BAUD_C = 4
)
(
    // Clock and reset
    input wire logic                     sys_clk,
    input wire logic                     rst_n,
    // Watched inputs
    input wire logic                     pass_a,
    input wire logic                     pass_b,
    input wire logic                     supply_low,
    input wire logic                     supply_high,
    // Watched outputs
    input wire vapour_pkg::lamp_colour_t condition_lamp,
    input wire logic                     power_lamp,
    input wire logic                     shutdown_a,
    input wire logic                     shutdown_b,
    input wire logic                     stray_alarm,
    input wire logic                     device_error,
    input wire logic                     bus_txd
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Low run length on the bus line; a run must be whole bit times
    int unsigned low_q;
    wire         any_sd = shutdown_a | shutdown_b;
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            low_q <= 0;
        else
            low_q <= bus_txd ? 0 : low_q + 1;
    property p_err_on; supply_high [*5] |-> device_error; endproperty
    a_err_on: assert property (p_err_on) else $error("device_error missing");
    property p_err_off; !supply_high [*5] |-> !device_error; endproperty
    a_err_off: assert property (p_err_off) else $error("device_error stuck");
    property p_pwr_steady; (!supply_low && !supply_high) [*8] |-> power_lamp; endproperty
    a_pwr_steady: assert property (p_pwr_steady) else $error("power lamp not lit");
    property p_pwr_fast; supply_high [*2] |-> ##[1:60] ($changed(power_lamp) || !supply_high); endproperty
    a_pwr_fast: assert property (p_pwr_fast) else $error("power lamp not blinking fast");
    property p_pwr_slow; (supply_low && !supply_high) [*2] |-> ##[1:100] ($changed(power_lamp) || !supply_low); endproperty
    a_pwr_slow: assert property (p_pwr_slow) else $error("power lamp not blinking slow");
    property p_stray_hold; stray_alarm |=> stray_alarm; endproperty
    a_stray_hold: assert property (p_stray_hold) else $error("stray alarm dropped");
    property p_sd_a_hold; $fell(shutdown_a) |-> $past(pass_a, 2) || $past(pass_a, 3) || $past(pass_a, 4); endproperty
    a_sd_a_hold: assert property (p_sd_a_hold) else $error("shutdown_a cleared without pass");
    property p_sd_b_hold; $fell(shutdown_b) |-> $past(pass_b, 2) || $past(pass_b, 3) || $past(pass_b, 4); endproperty
    a_sd_b_hold: assert property (p_sd_b_hold) else $error("shutdown_b cleared without pass");
    property p_red_sd; condition_lamp == LAMP_RED |-> any_sd or ##1 any_sd or $past(any_sd); endproperty
    a_red_sd: assert property (p_red_sd) else $error("red lamp without shutdown");
    property p_bit_time; $rose(bus_txd) |-> low_q % BAUD_C == 0; endproperty
    a_bit_time: assert property (p_bit_time) else $error("bus low run not whole bits");
    c_shutdown: cover property ($rose(shutdown_a));
    c_stray: cover property ($rose(stray_alarm));
    c_frame: cover property ($fell(bus_txd));
endmodule
